// file: rtl/timer_counter_pkg.sv
// shared constants, register map and carrier types of the 16-bit timer/counter
package timer_counter_pkg;
  localparam int COUNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  localparam logic [AXI_ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFS_COUNT_LOW = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFS_COUNT_HIGH = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFS_FLAG_TWO = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] OFS_ENABLE_TWO = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] OFS_AUX_CONFIG = 8'h14;

  localparam int OVERFLOW_FLAG_BIT = 1;
  localparam int OVERFLOW_IRQ_ENABLE_BIT = 1;
  localparam int AUX_OSC_ENABLE_BIT = 0;

  localparam logic [BYTE_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
  localparam int NUM_UNITS = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic wide_access_enable;
    logic timebase_select_hi;
    logic [1:0] input_prescale_select;
    logic timebase_select_lo;
    logic ext_sync_bypass;
    logic clock_source_select;
    logic counter_on;
  } counter_control_s;

  typedef struct packed {
    logic [3:0] compare_unit_mode_bits;
    logic [COUNT_W-1:0] compare_unit_match_value;
  } compare_unit_s;

  typedef struct packed {
    logic [COUNT_W-1:0] unit_two;
    logic [COUNT_W-1:0] unit_one;
    logic unit_two_uses_this;
    logic unit_one_uses_this;
  } timebase_route_s;
endpackage

// file: rtl/input_prescaler.sv
// selectable 1:1 to 1:8 divider of counting ticks
`timescale 1ns/1ps
module input_prescaler #(
  parameter int STAGES = 3
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic clear_in,
  input wire logic [1:0] select_in,
  output logic tick_out
);
  logic [STAGES-1:0] div_ff;
  logic [STAGES-1:0] mask;

  // mask of low bits that must all be set before a tick passes
  always_comb begin
    mask = '0;
    for (int i = 0; i < STAGES; i++) begin
      if (i < int'(select_in)) begin
        mask[i] = 1'b1;
      end
    end
  end

  assign tick_out = tick_in && ((div_ff & mask) == mask);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_ff <= '0;
    end else if (clear_in) begin
      div_ff <= '0;
    end else if (tick_in) begin
      div_ff <= tick_out ? '0 : div_ff + {{(STAGES-1){1'b0}}, 1'b1};
    end
  end
endmodule

// file: rtl/sixteen_bit_timer_counter.sv
// 16-bit timer/counter with AXI4-Lite register access
// Operation
// R01: internal source counts every instruction cycle
// R02: external source counts rising edges after first fall
// R03: sync bypass bit only matters with external source
// R04: prescale field divides by 1, 2, 4, 8
// R05: counter on bit runs or stops counting
// R06: wide access bit selects 16-bit or byte access
// R07: timebase field routes timers to compare units
// R08: count wraps FFFFh to 0000h as overflow
// R09: overflow sets sticky flag; enable gates interrupt
// R10: special event compare match clears the count
// R11: trigger clear never sets the overflow flag
// R12: software count write beats a coincident trigger
// R13: software uses trigger only in synchronous modes
// R14: first unit match value acts as period
// R15: aux oscillator forces pins input, reading zero
// R16: software ignores sync setting on aux system clock
// R17: power-on reset clears control register
// R18: wide mode buffers high byte via low access
// R19: low byte write clears prescaler, high does not
`timescale 1ns/1ps
module sixteen_bit_timer_counter #(
  parameter int PRESCALE_STAGES = 3
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [timer_counter_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [timer_counter_pkg::AXI_DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [timer_counter_pkg::AXI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [timer_counter_pkg::AXI_DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic aux_clock_pin_in,
  input wire logic [1:0] aux_pins_in,
  input wire timer_counter_pkg::compare_unit_s compare_unit_one_in,
  input wire timer_counter_pkg::compare_unit_s compare_unit_two_in,
  input wire logic [timer_counter_pkg::COUNT_W-1:0] other_timer_count_in,
  output timer_counter_pkg::timebase_route_s timebase_route_out,
  output logic [1:0] aux_pins_read_out,
  output logic aux_pins_forced_input_out,
  output logic irq_out
);
  import timer_counter_pkg::*;

  counter_control_s control_ff;
  logic [COUNT_W-1:0] count_ff;
  logic [BYTE_W-1:0] high_buffer_ff;
  logic overflow_flag_ff;
  logic overflow_irq_enable_ff;
  logic aux_oscillator_enable_ff;

  logic aw_held_ff;
  logic w_held_ff;
  logic [AXI_ADDR_W-1:0] awaddr_ff;
  logic [AXI_DATA_W-1:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [AXI_DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;

  logic ext_meta_ff;
  logic ext_sync_ff;
  logic ext_prev_ff;
  logic ext_armed_ff;

  timebase_route_s route_ff;
  logic [1:0] pins_read_ff;
  logic pins_forced_ff;
  logic irq_ff;

  function automatic logic reg_hit(input logic [AXI_ADDR_W-1:0] addr,
                                   input logic [AXI_ADDR_W-1:0] ofs);
    reg_hit = (addr[AXI_ADDR_W-1:2] == ofs[AXI_ADDR_W-1:2]);
  endfunction

  function automatic logic reg_mapped(input logic [AXI_ADDR_W-1:0] addr);
    reg_mapped = reg_hit(addr, OFS_CONTROL) || reg_hit(addr, OFS_COUNT_LOW) ||
                 reg_hit(addr, OFS_COUNT_HIGH) || reg_hit(addr, OFS_FLAG_TWO) ||
                 reg_hit(addr, OFS_ENABLE_TWO) || reg_hit(addr, OFS_AUX_CONFIG);
  endfunction

  // write strobe pulses, one cycle, only the low byte lane carries register data
  logic do_write;
  logic wr_lane;
  logic wr_control;
  logic wr_low;
  logic wr_high;
  logic wr_flag;
  logic wr_enable;
  logic wr_aux;
  logic [BYTE_W-1:0] wr_byte;
  logic do_read;
  logic rd_low;

  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_lane = do_write && wstrb_ff[0];
  assign wr_byte = wdata_ff[BYTE_W-1:0];
  assign wr_control = wr_lane && reg_hit(awaddr_ff, OFS_CONTROL);
  assign wr_low = wr_lane && reg_hit(awaddr_ff, OFS_COUNT_LOW);
  assign wr_high = wr_lane && reg_hit(awaddr_ff, OFS_COUNT_HIGH);
  assign wr_flag = wr_lane && reg_hit(awaddr_ff, OFS_FLAG_TWO);
  assign wr_enable = wr_lane && reg_hit(awaddr_ff, OFS_ENABLE_TWO);
  assign wr_aux = wr_lane && reg_hit(awaddr_ff, OFS_AUX_CONFIG);
  assign do_read = s_axi_arvalid_in && arready_ff;
  assign rd_low = do_read && reg_hit(s_axi_araddr_in, OFS_COUNT_LOW);

  // external clock edge qualification
  logic ext_level;
  logic ext_rise;
  logic ext_fall;

  assign ext_level = control_ff.ext_sync_bypass ? aux_clock_pin_in : ext_sync_ff; // see R03
  assign ext_rise = ext_level && !ext_prev_ff && ext_armed_ff; // see R02
  assign ext_fall = !ext_level && ext_prev_ff;

  // the raw path skips the two-stage delay; trigger clears in that mode may be missed
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      ext_meta_ff <= aux_clock_pin_in;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_level;
    end
  end

  // a counter that is off must see a fresh falling edge before counting again
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_armed_ff <= 1'b0;
    end else if (!control_ff.counter_on || !control_ff.clock_source_select) begin
      ext_armed_ff <= 1'b0;
    end else if (ext_fall) begin
      ext_armed_ff <= 1'b1; // see R02
    end
  end

  logic source_tick;
  logic count_tick;

  always_comb begin
    source_tick = 1'b0;
    if (control_ff.counter_on) begin // see R05
      if (control_ff.clock_source_select) begin
        source_tick = ext_rise; // see R02
      end else begin
        source_tick = 1'b1; // see R01
      end
    end
  end

  input_prescaler #(
    .STAGES(PRESCALE_STAGES)
  ) u_prescaler (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(source_tick),
    .clear_in(wr_low), // see R19
    .select_in(control_ff.input_prescale_select), // see R04
    .tick_out(count_tick)
  );

  // timebase routing and special event triggers
  logic this_feeds [NUM_UNITS];
  compare_unit_s units [NUM_UNITS];
  logic [NUM_UNITS-1:0] unit_trigger;
  logic trigger_clear;

  assign units[0] = compare_unit_one_in;
  assign units[1] = compare_unit_two_in;
  assign this_feeds[0] = control_ff.timebase_select_hi; // see R07
  assign this_feeds[1] = control_ff.timebase_select_hi || control_ff.timebase_select_lo; // see R07

  generate
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
      assign unit_trigger[u] = this_feeds[u] &&
          (units[u].compare_unit_mode_bits == MODE_SPECIAL_EVENT) &&
          (count_ff == units[u].compare_unit_match_value); // see R10 R14
    end
  endgenerate

  assign trigger_clear = |unit_trigger;

  // count register: software write, then trigger clear, then increment
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_ff <= COUNT_RESET;
    end else if (wr_low) begin
      if (control_ff.wide_access_enable) begin
        count_ff <= {high_buffer_ff, wr_byte}; // see R18 R12
      end else begin
        count_ff[BYTE_W-1:0] <= wr_byte; // see R06 R12
      end
    end else if (wr_high && !control_ff.wide_access_enable) begin
      count_ff[COUNT_W-1:BYTE_W] <= wr_byte; // see R06 R12
    end else if (trigger_clear) begin
      count_ff <= COUNT_RESET; // see R10 R14
    end else if (count_tick) begin
      count_ff <= count_ff + 16'h0001; // see R08
    end
  end

  logic overflow_event;
  logic count_written;

  assign count_written = wr_low || (wr_high && !control_ff.wide_access_enable);
  assign overflow_event = count_tick && (count_ff == COUNT_MAX) &&
                          !count_written && !trigger_clear; // see R08 R11

  // high byte buffer, shared by both directions in wide mode
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      high_buffer_ff <= 8'h00;
    end else if (wr_high && control_ff.wide_access_enable) begin
      high_buffer_ff <= wr_byte; // see R18
    end else if (rd_low && control_ff.wide_access_enable) begin
      high_buffer_ff <= count_ff[COUNT_W-1:BYTE_W]; // see R18
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      control_ff <= CONTROL_RESET; // see R17
    end else if (wr_control) begin
      control_ff <= wr_byte;
    end
  end

  // hardware set wins over a coincident software clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      overflow_flag_ff <= 1'b0;
    end else if (overflow_event) begin
      overflow_flag_ff <= 1'b1; // see R09
    end else if (wr_flag) begin
      overflow_flag_ff <= wr_byte[OVERFLOW_FLAG_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      overflow_irq_enable_ff <= 1'b0;
      aux_oscillator_enable_ff <= 1'b0;
    end else begin
      if (wr_enable) begin
        overflow_irq_enable_ff <= wr_byte[OVERFLOW_IRQ_ENABLE_BIT];
      end
      if (wr_aux) begin
        aux_oscillator_enable_ff <= wr_byte[AUX_OSC_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= overflow_flag_ff && overflow_irq_enable_ff; // see R09
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pins_read_ff <= 2'h0;
      pins_forced_ff <= 1'b0;
    end else begin
      pins_forced_ff <= aux_oscillator_enable_ff; // see R15
      pins_read_ff <= aux_oscillator_enable_ff ? 2'h0 : aux_pins_in; // see R15
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      route_ff <= '0;
    end else begin
      route_ff.unit_one_uses_this <= this_feeds[0]; // see R07
      route_ff.unit_two_uses_this <= this_feeds[1];
      route_ff.unit_one <= this_feeds[0] ? count_ff : other_timer_count_in;
      route_ff.unit_two <= this_feeds[1] ? count_ff : other_timer_count_in;
    end
  end

  // write channel: address and data taken in either order, response after both
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
      awready_ff <= 1'b1;
    end else if (s_axi_awvalid_in && awready_ff) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr_in;
      awready_ff <= 1'b0;
    end else if (bvalid_ff && s_axi_bready_in) begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      w_held_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= 4'h0;
      wready_ff <= 1'b1;
    end else if (s_axi_wvalid_in && wready_ff) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata_in;
      wstrb_ff <= s_axi_wstrb_in;
      wready_ff <= 1'b0;
    end else if (bvalid_ff && s_axi_bready_in) begin
      w_held_ff <= 1'b0;
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= reg_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read data, with the low byte read loading the high buffer in wide mode
  logic [BYTE_W-1:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (reg_hit(s_axi_araddr_in, OFS_CONTROL)) begin
      rd_byte = control_ff;
    end else if (reg_hit(s_axi_araddr_in, OFS_COUNT_LOW)) begin
      rd_byte = count_ff[BYTE_W-1:0];
    end else if (reg_hit(s_axi_araddr_in, OFS_COUNT_HIGH)) begin
      rd_byte = control_ff.wide_access_enable ? high_buffer_ff :
                count_ff[COUNT_W-1:BYTE_W]; // see R06 R18
    end else if (reg_hit(s_axi_araddr_in, OFS_FLAG_TWO)) begin
      rd_byte[OVERFLOW_FLAG_BIT] = overflow_flag_ff;
    end else if (reg_hit(s_axi_araddr_in, OFS_ENABLE_TWO)) begin
      rd_byte[OVERFLOW_IRQ_ENABLE_BIT] = overflow_irq_enable_ff;
    end else if (reg_hit(s_axi_araddr_in, OFS_AUX_CONFIG)) begin
      rd_byte[AUX_OSC_ENABLE_BIT] = aux_oscillator_enable_ff;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (do_read) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {{(AXI_DATA_W-BYTE_W){1'b0}}, rd_byte};
      rresp_ff <= reg_mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready_in) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out = wready_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign timebase_route_out = route_ff;
  assign aux_pins_read_out = pins_read_ff;
  assign aux_pins_forced_input_out = pins_forced_ff;
  assign irq_out = irq_ff;
endmodule

// file: tb/sixteen_bit_timer_counter_checker.sv
// port-level assertions for the 16-bit timer/counter
`timescale 1ns/1ps
module sixteen_bit_timer_counter_checker #(
  parameter int PRESCALE_STAGES = 3
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [timer_counter_pkg::AXI_DATA_W-1:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire timer_counter_pkg::compare_unit_s compare_unit_one_in,
  input wire logic [timer_counter_pkg::COUNT_W-1:0] other_timer_count_in,
  input wire timer_counter_pkg::timebase_route_s timebase_route_out,
  input wire logic [1:0] aux_pins_read_out,
  input wire logic aux_pins_forced_input_out
);
  import timer_counter_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_wr_answer;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> ##1 s_axi_bvalid_out;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_answer;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_byte_data;
    s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000;
  endproperty
  a_byte_data: assert property (p_byte_data) else $error("upper read bits set");
  property p_route_pair;
    timebase_route_out.unit_one_uses_this |-> timebase_route_out.unit_two_uses_this;
  endproperty
  a_route_pair: assert property (p_route_pair) else $error("unit one alone routed");
  property p_route_other;
    !$past(rst_in) && !timebase_route_out.unit_one_uses_this
      |-> timebase_route_out.unit_one == $past(other_timer_count_in);
  endproperty
  a_route_other: assert property (p_route_other) else $error("unit one base wrong");
  // a write landing at the trigger edge shows as bvalid and wins
  property p_trigger;
    timebase_route_out.unit_one_uses_this && !s_axi_bvalid_out
      && compare_unit_one_in.compare_unit_mode_bits == MODE_SPECIAL_EVENT
      && timebase_route_out.unit_one == compare_unit_one_in.compare_unit_match_value
      && $stable(compare_unit_one_in) |=> timebase_route_out.unit_one == COUNT_RESET;
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger did not clear");
  property p_aux;
    aux_pins_forced_input_out |-> aux_pins_read_out == 2'h0;
  endproperty
  a_aux: assert property (p_aux) else $error("forced pins not zero");
endmodule

bind sixteen_bit_timer_counter sixteen_bit_timer_counter_checker #(
  .PRESCALE_STAGES(PRESCALE_STAGES)
) i_chk (
  .clk_in, .rst_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .compare_unit_one_in, .other_timer_count_in, .timebase_route_out,
  .aux_pins_read_out, .aux_pins_forced_input_out
);

// file: tb/sixteen_bit_timer_counter_test.sv
// self-checking bench for the 16-bit timer/counter over AXI4-Lite
`timescale 1ns/1ps
module sixteen_bit_timer_counter_test;
  import timer_counter_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [AXI_DATA_W-1:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, forced, irq;
  logic [1:0] bresp, rresp, pins_rd, resp;
  logic [1:0] aux_pins = 2'h3;
  logic aux_clk = 1'b0;
  logic [2:0] phase = 3'h0;
  compare_unit_s cu_one = '0;
  timebase_route_s route;
  logic [15:0] c0, top;
  logic [31:0] rdat;
  int mismatches = 0;
  int comparisons = 0;
  // counting table: control value and counts expected over 64 cycles
  localparam logic [7:0] CTL [9] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h45, 8'h43, 8'h47,
    8'h53, 8'h40};
  localparam logic [7:0] STEP [9] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h40, 8'h08, 8'h08, 8'h04,
    8'h00};
  localparam logic [7:0] TBS [4] = '{8'h00, 8'h08, 8'h40, 8'h48};
  localparam logic [1:0] USE [4] = '{2'h0, 2'h2, 2'h3, 2'h3};

  sixteen_bit_timer_counter i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .aux_clock_pin_in(aux_clk), .aux_pins_in(aux_pins), .compare_unit_one_in(cu_one),
    .compare_unit_two_in('0), .other_timer_count_in(16'h5A5A), .timebase_route_out(route),
    .aux_pins_read_out(pins_rd), .aux_pins_forced_input_out(forced), .irq_out(irq)
  );

  always #50 clk_in = ~clk_in;
  // external count clock: one rising edge every 8 cycles
  always @(posedge clk_in) begin
    phase <= phase + 3'h1;
    aux_clk <= phase[2];
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stall();
    mismatches++;
    $display("BAD bus answer expected in time seen none");
    complete_run();
  endtask
  task automatic wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    resp = bresp;
    if (n == 50) stall();
  endtask
  task automatic rd(input logic [AXI_ADDR_W-1:0] a);
    int n;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    rdat = rdata;
    resp = rresp;
    if (n == 50) stall();
  endtask
  task automatic rc(input string what, input logic [AXI_ADDR_W-1:0] a, input logic [31:0] e);
    rd(a);
    check(what, rdat, e);
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rc("control", OFS_CONTROL, 32'h0);
    rc("flag reg", OFS_FLAG_TWO, 32'h0);
    rd(8'h20);
    check("unmapped read resp", 32'(resp), 32'(RESP_SLVERR));
    check("unmapped read data", rdat, 32'h0);
    wr(8'h20, 32'hFF);
    check("unmapped write resp", 32'(resp), 32'(RESP_SLVERR));
    $display("test reset_map done");
    wr(OFS_COUNT_HIGH, 32'h12);
    wr(OFS_COUNT_LOW, 32'h34);
    rc("byte high", OFS_COUNT_HIGH, 32'h12);
    rc("byte low", OFS_COUNT_LOW, 32'h34);
    wr(OFS_CONTROL, 32'h80);
    rc("wide low", OFS_COUNT_LOW, 32'h34);
    rc("wide buffer", OFS_COUNT_HIGH, 32'h12);
    wr(OFS_COUNT_HIGH, 32'hAB);
    wr(OFS_COUNT_LOW, 32'hCD);
    wr(OFS_CONTROL, 32'h00);
    rc("loaded high", OFS_COUNT_HIGH, 32'hAB);
    rc("loaded low", OFS_COUNT_LOW, 32'hCD);
    $display("test access done");
    foreach (TBS[i]) begin
      wr(OFS_CONTROL, 32'(TBS[i]));
      repeat (2) @(posedge clk_in);
      check("route flags", 32'(route[1:0]), 32'(USE[i]));
      // count is stopped at ABCD here, the other timer is tied to 5A5A
      check("unit one base", 32'(route.unit_one), USE[i][0] ? 32'hABCD : 32'h5A5A);
      check("unit two base", 32'(route.unit_two), USE[i][1] ? 32'hABCD : 32'h5A5A);
    end
    foreach (CTL[i]) begin
      wr(OFS_CONTROL, 32'(CTL[i]));
      repeat (16) @(posedge clk_in);
      c0 = route.unit_one;
      repeat (64) @(posedge clk_in);
      check("count step", 32'(route.unit_one - c0), 32'(STEP[i]));
    end
    $display("test counting done");
    wr(OFS_ENABLE_TWO, 32'h2);
    wr(OFS_CONTROL, 32'h00);
    wr(OFS_COUNT_HIGH, 32'hFF);
    wr(OFS_COUNT_LOW, 32'hF0);
    check("irq idle", 32'(irq), 32'h0);
    wr(OFS_CONTROL, 32'h01);
    repeat (30) @(posedge clk_in);
    wr(OFS_CONTROL, 32'h00);
    rc("high after wrap", OFS_COUNT_HIGH, 32'h00);
    rc("flag after wrap", OFS_FLAG_TWO, 32'h02);
    check("irq raised", 32'(irq), 32'h1);
    wr(OFS_ENABLE_TWO, 32'h0);
    repeat (2) @(posedge clk_in);
    check("irq masked", 32'(irq), 32'h0);
    wr(OFS_FLAG_TWO, 32'h0);
    rc("flag cleared", OFS_FLAG_TWO, 32'h0);
    $display("test overflow done");
    cu_one <= {MODE_SPECIAL_EVENT, 16'h0010};
    wr(OFS_COUNT_HIGH, 32'h00);
    wr(OFS_COUNT_LOW, 32'h00);
    wr(OFS_CONTROL, 32'h41);
    top = 16'h0000;
    repeat (100) begin
      @(posedge clk_in);
      if (route.unit_one > top) top = route.unit_one;
    end
    check("period top", 32'(top), 32'h10);
    rc("flag after trigger", OFS_FLAG_TWO, 32'h0);
    cu_one <= '0;
    wr(OFS_CONTROL, 32'h00);
    $display("test trigger done");
    wr(OFS_AUX_CONFIG, 32'h1);
    repeat (2) @(posedge clk_in);
    check("pins forced", 32'(forced), 32'h1);
    check("pins read", 32'(pins_rd), 32'h0);
    wr(OFS_AUX_CONFIG, 32'h0);
    repeat (3) @(posedge clk_in);
    check("pins released", 32'(forced), 32'h0);
    check("pins read back", 32'(pins_rd), 32'h3);
    $display("test aux done");
    complete_run();
  end
endmodule
